/* File: logic/scl_consts.svh */
// scl_consts.svh: offsets, field positions, default values and times of the loader
// assumes: included by the loader module only, by its bare name
`ifndef SCL_CONSTS_SVH
`define SCL_CONSTS_SVH

// register offsets (byte addresses, one 32-bit word each)
`define SCL_OFS_CTRL 4'h0
`define SCL_OFS_STATUS 4'h4
`define SCL_OFS_FRAMES 4'h8
`define SCL_OFS_CONFIG 4'hc
// control fields
`define SCL_CTRL_TGT_LSB 0
`define SCL_CTRL_RESTART_BIT 8
`define SCL_CTRL_RESET 2'h3
// status fields
`define SCL_ST_DONE_BIT 0
`define SCL_ST_BUSY_BIT 1
`define SCL_ST_LV_BIT 2
`define SCL_ST_FV_BIT 3
`define SCL_ST_INTG_BIT 4
`define SCL_ST_ROW_LSB 8

// front-end defaults
`define SCL_AFE_OPERATION 16'h0080
`define SCL_AFE_GAIN_HI 16'h0194
`define SCL_AFE_GAIN_LO 16'h015e
`define SCL_AFE_CLAMP 16'h0060
`define SCL_AFE_CONTROL 16'h0008
`define SCL_AFE_PIXGAIN 16'h002b
// timing generator register numbers and sub-field slots of register 1
`define SCL_TG_REG_FPTR 8'h00
`define SCL_TG_REG_GEN 8'h02
`define SCL_TG_REG_INTG 8'h04
`define SCL_TG_R1_BASE 8'h10
// timing generator defaults
`define SCL_FPTR_FREE 16'h0000
`define SCL_FPTR_STILL 16'h0001
`define SCL_FPTR_BIN 16'h0002
`define SCL_PPL_ONE 16'h0680
`define SCL_PPL_TWO 16'h0340
`define SCL_LV_START 16'h0009
`define SCL_LV_QUAD 16'h0000
`define SCL_LV_END_ONE 16'h0674
`define SCL_LV_END_TWO 16'h033a
`define SCL_CLP1_S_ONE 16'h065e
`define SCL_CLP1_E_ONE 16'h0668
`define SCL_CLP1_S_TWO 16'h033c
`define SCL_CLP1_E_TWO 16'h033d
`define SCL_CLP2_ZERO 16'h0000
`define SCL_DRIVE24_OFF 16'h0000
`define SCL_DLL_RANGE 16'h0008
`define SCL_GEN_PROGRAM 16'h0000
`define SCL_GEN_EXECUTE 16'h0001
`define SCL_INTG_NONE 16'h0ff8
`define SCL_INTG_STEP_FREE 16'h0098
`define SCL_INTG_STEP_STILL 16'h01c8

// times
`define SCL_CLK_MHZ 40
`define SCL_SER_HALF_NS 50
`define SCL_PIX_PERIOD_NS 25

`endif

/* File: logic/scl_pkg.sv */
// scl_pkg: types shared by the configuration loader
// assumes: nothing, not even the constants header
package scl_pkg;
  typedef enum logic [2:0] {
    SCL_ST_CAPTURE = 3'b000,
    SCL_ST_LOAD = 3'b001,
    SCL_ST_SHIFT = 3'b010,
    SCL_ST_GAP = 3'b011,
    SCL_ST_DONE = 3'b100
  } scl_state_t;

  typedef enum logic [1:0] {
    SCL_TGT_NONE = 2'b00,
    SCL_TGT_AFE1 = 2'b01,
    SCL_TGT_AFE2 = 2'b10,
    SCL_TGT_TG = 2'b11
  } scl_target_t;
endpackage

/* File: logic/scl_loader.sv */
// scl_loader: reset-time default loader for two front-end converters and a timing generator,
// then forwarding of host serial traffic and monitoring of the timing generator
// assumes: 40 MHz clk, Avalon-MM master on the register port, switches and link pins asynchronous
//
// Notes on behaviour
// - power-up, reset button or remote reset toggle restart the whole default load
// - write all front-end registers first, then timing generator tables and registers
// - after loading, keep watching timing generator activity and the host serial link
// - front-end register 0 gets 128, register 3 gets 8
// - front-end register 1 gets 404 with variant switch high, 350 when low
// - front-end register 2 gets 96, the clamp code
// - front-end registers 4 to 7 get 43, unity pixel gain
// - frame table pointer: 0 free-running, 1 still capture, 2 two-by-two binning
// - pixels per line 1664 single channel, 832 dual channel
// - line-valid start pixel 9, quadrature start 0
// - line-valid end pixel 1652 single channel, 826 dual channel
// - first clamp window 1630-1640 or 828-829, second window zero
// - all 24 mA high-drive enable bits written zero
// - delay-locked loop range field written 8
// - host rewrites of clamp positions never change the reapplied defaults
// - default integration line from select inputs, full down to one-eighth frame
// - new integration select takes effect only after the next restart: button, remote input or control register kick
// - pixel data clock runs at 40 MHz, one pixel per 25 ns
// - timing generator load opens with program mode and closes with execution mode
// - channel switch high means dual output, low means single output
// - capture switch high means still capture, low means free-running
// - binning switch high means two-by-two binning, low means none
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "scl_consts.svh"

module scl_loader
  import scl_pkg::*;
#(
  parameter int ROWS = 30,
  parameter int FRAME_BITS = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // board inputs, asynchronous
  input wire logic board_reset_btn_n,
  input wire logic remote_reset_input,
  input wire logic channel_count_switch,
  input wire logic binning_switch,
  input wire logic capture_mode_switch,
  input wire logic sensor_variant_switch,
  input wire logic [4:0] integration_select_inputs,
  // host 3-wire link, asynchronous
  input wire logic host_sclk,
  input wire logic host_sdata,
  input wire logic host_sload_n,
  // timing generator monitor, asynchronous
  input wire logic tg_line_valid,
  input wire logic tg_frame_valid,
  input wire logic tg_intg_start,
  // serial outputs to converters and timing generator
  output logic ser_sclk,
  output logic ser_sdata,
  output logic sload_afe1_n,
  output logic sload_afe2_n,
  output logic sload_tg_n,
  // status and pixel clock gate
  output logic load_done,
  output logic pixel_data_clock_en,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // least half-period of the generated serial clock, rounded up, at least one cycle
  localparam int HALF_RAW = (`SCL_SER_HALF_NS * `SCL_CLK_MHZ + 999) / 1000;
  localparam int HALF_CYC = (HALF_RAW < 1) ? 1 : HALF_RAW;
  // one pixel per clk period at this rate; the gate enables the clk onto the pixel clock pin
  localparam int PIX_CYC = (`SCL_PIX_PERIOD_NS * `SCL_CLK_MHZ) / 1000;

  //////////////////////////////////////////////////////////////////////////////////////////
  // input synchronisers: first stage feeds only the second

  localparam int NSYNC = 16;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] async_in;

  assign async_in = {board_reset_btn_n, remote_reset_input, integration_select_inputs,
                     sensor_variant_switch, capture_mode_switch, binning_switch,
                     channel_count_switch, host_sclk, host_sdata, host_sload_n,
                     tg_line_valid, tg_frame_valid};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // button bit starts pressed: restart holds until real switch levels reach stage two
      sync1_r <= 16'h0004;
      sync2_r <= 16'h0004;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  logic btn_n_s, rem_s, host_sclk_s, host_sdata_s, host_sload_n_s, lv_s, fv_s;
  logic [8:0] sw_s;
  assign btn_n_s = sync2_r[15];
  assign rem_s = sync2_r[14];
  assign sw_s = sync2_r[13:5];
  assign host_sclk_s = sync2_r[4];
  assign host_sdata_s = sync2_r[3];
  assign host_sload_n_s = sync2_r[2];
  assign lv_s = sync2_r[1];
  assign fv_s = sync2_r[0];

  // intg_start has its own pair so the monitor edge detector stays off the first stage
  logic intg1_r, intg2_r, intg3_r, fv3_r, lv3_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intg1_r <= 1'b0;
      intg2_r <= 1'b0;
      intg3_r <= 1'b0;
      fv3_r <= 1'b0;
      lv3_r <= 1'b0;
    end else begin
      intg1_r <= tg_intg_start;
      intg2_r <= intg1_r;
      intg3_r <= intg2_r;
      fv3_r <= fv_s;
      lv3_r <= lv_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // default table; cfg = {intg[4:0], variant, still, binning, dual}

  function automatic logic [15:0] intg_line(input logic still, input logic [4:0] sel);
    logic [15:0] k;
    k = 16'(4'd8 - {1'b0, sel[2:0]});
    if (sel == 5'd0 || sel > 5'd7) begin
      intg_line = `SCL_INTG_NONE;
    end else if (still) begin
      intg_line = 16'(k * `SCL_INTG_STEP_STILL);
    end else begin
      intg_line = 16'(k * `SCL_INTG_STEP_FREE);
    end
  endfunction

  function automatic logic [15:0] afe_val(input logic [2:0] a, input logic variant);
    case (a)
      3'd0: afe_val = `SCL_AFE_OPERATION;
      3'd1: afe_val = variant ? `SCL_AFE_GAIN_HI : `SCL_AFE_GAIN_LO;
      3'd2: afe_val = `SCL_AFE_CLAMP;
      3'd3: afe_val = `SCL_AFE_CONTROL;
      default: afe_val = `SCL_AFE_PIXGAIN;
    endcase
  endfunction

  // rows 0..15 front-ends, 16..29 timing generator; constant table, so host writes
  // never touch what the next restart reloads
  function automatic logic [25:0] row_of(input logic [4:0] i, input logic [8:0] c);
    logic dual;
    logic [7:0] a;
    logic [15:0] d;
    scl_target_t t;
    dual = c[0];
    a = 8'h00;
    d = 16'h0000;
    t = SCL_TGT_TG;
    if (i < 5'd16) begin
      t = i[3] ? SCL_TGT_AFE2 : SCL_TGT_AFE1;
      a = {5'd0, i[2:0]};
      d = afe_val(i[2:0], c[3]);
    end else begin
      case (i)
        5'd16: begin
          a = `SCL_TG_REG_GEN;
          d = `SCL_GEN_PROGRAM;
        end
        5'd17: begin
          a = `SCL_TG_REG_FPTR;
          if (c[1]) begin
            d = `SCL_FPTR_BIN;
          end else if (c[2]) begin
            d = `SCL_FPTR_STILL;
          end else begin
            d = `SCL_FPTR_FREE;
          end
        end
        5'd18: d = dual ? `SCL_PPL_TWO : `SCL_PPL_ONE;
        5'd19: d = `SCL_LV_START;
        5'd20: d = `SCL_LV_QUAD;
        5'd21: d = dual ? `SCL_LV_END_TWO : `SCL_LV_END_ONE;
        5'd22: d = dual ? `SCL_CLP1_S_TWO : `SCL_CLP1_S_ONE;
        5'd23: d = dual ? `SCL_CLP1_E_TWO : `SCL_CLP1_E_ONE;
        5'd24: d = `SCL_CLP2_ZERO;
        5'd25: d = `SCL_CLP2_ZERO;
        5'd26: d = `SCL_DRIVE24_OFF;
        5'd27: d = `SCL_DLL_RANGE;
        5'd28: begin
          a = `SCL_TG_REG_INTG;
          d = intg_line(c[2], c[8:4]);
        end
        default: begin
          a = `SCL_TG_REG_GEN;
          d = `SCL_GEN_EXECUTE;
        end
      endcase
      if (i >= 5'd18 && i <= 5'd27) begin
        a = 8'(`SCL_TG_R1_BASE + 8'(i - 5'd18));
      end
    end
    row_of = {t, a, d};
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////
  // loader state

  scl_state_t state_r, state_nxt;
  logic [8:0] cfg_r, cfg_nxt;
  logic [4:0] row_r, row_nxt;
  logic [FRAME_BITS-1:0] sh_r, sh_nxt;
  logic [4:0] bits_r, bits_nxt;
  logic [7:0] half_r, half_nxt;
  scl_target_t tgt_r, tgt_nxt;
  logic sclk_r, sclk_nxt, sdata_r, sdata_nxt;
  logic afe1_n_r, afe1_n_nxt, afe2_n_r, afe2_n_nxt, tg_n_r, tg_n_nxt;
  logic done_r, done_nxt, pix_en_r, pix_en_nxt;
  logic restart;
  logic half_tick;
  logic [25:0] row_word;
  logic [1:0] ctrl_tgt_r;
  logic soft_restart_r;

  // button low, remote input high or a software kick hold the loader in restart
  assign restart = !btn_n_s || rem_s || soft_restart_r;
  assign half_tick = (half_r == 8'(HALF_CYC - 1));
  assign row_word = row_of(row_r, cfg_r);

  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    row_nxt = row_r;
    sh_nxt = sh_r;
    bits_nxt = bits_r;
    half_nxt = half_tick ? 8'h00 : half_r + 8'h01;
    tgt_nxt = tgt_r;
    sclk_nxt = sclk_r;
    sdata_nxt = sdata_r;
    afe1_n_nxt = afe1_n_r;
    afe2_n_nxt = afe2_n_r;
    tg_n_nxt = tg_n_r;
    done_nxt = done_r;
    pix_en_nxt = pix_en_r;
    if (restart) begin
      state_nxt = SCL_ST_CAPTURE;
      row_nxt = 5'd0;
      half_nxt = 8'h00;
      sclk_nxt = 1'b0;
      sdata_nxt = 1'b0;
      afe1_n_nxt = 1'b1;
      afe2_n_nxt = 1'b1;
      tg_n_nxt = 1'b1;
      done_nxt = 1'b0;
      pix_en_nxt = 1'b0;
    end else begin
      case (state_r)
        SCL_ST_CAPTURE: begin
          cfg_nxt = sw_s;
          state_nxt = SCL_ST_LOAD;
        end
        SCL_ST_LOAD: begin
          tgt_nxt = scl_target_t'(row_word[25:24]);
          sh_nxt = {row_word[23:0], {(FRAME_BITS - 24){1'b0}}} << 1;
          sdata_nxt = row_word[23];
          bits_nxt = 5'd0;
          half_nxt = 8'h00;
          afe1_n_nxt = (row_word[25:24] != SCL_TGT_AFE1);
          afe2_n_nxt = (row_word[25:24] != SCL_TGT_AFE2);
          tg_n_nxt = (row_word[25:24] != SCL_TGT_TG);
          state_nxt = SCL_ST_SHIFT;
        end
        SCL_ST_SHIFT: begin
          if (half_tick) begin
            sclk_nxt = !sclk_r;
            if (sclk_r) begin
              sdata_nxt = sh_r[FRAME_BITS-1];
              sh_nxt = sh_r << 1;
              bits_nxt = bits_r + 5'd1;
              if (bits_r == 5'(FRAME_BITS - 1)) begin
                afe1_n_nxt = 1'b1;
                afe2_n_nxt = 1'b1;
                tg_n_nxt = 1'b1;
                state_nxt = SCL_ST_GAP;
              end
            end
          end
        end
        SCL_ST_GAP: begin
          if (half_tick) begin
            if (row_r == 5'(ROWS - 1)) begin
              done_nxt = 1'b1;
              pix_en_nxt = 1'b1;
              state_nxt = SCL_ST_DONE;
            end else begin
              row_nxt = row_r + 5'd1;
              state_nxt = SCL_ST_LOAD;
            end
          end
        end
        SCL_ST_DONE: begin
          // host link forwarded only once loading is complete
          sclk_nxt = host_sclk_s;
          sdata_nxt = host_sdata_s;
          afe1_n_nxt = !(ctrl_tgt_r == SCL_TGT_AFE1 && !host_sload_n_s);
          afe2_n_nxt = !(ctrl_tgt_r == SCL_TGT_AFE2 && !host_sload_n_s);
          tg_n_nxt = !(ctrl_tgt_r == SCL_TGT_TG && !host_sload_n_s);
        end
        default: state_nxt = SCL_ST_CAPTURE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= SCL_ST_CAPTURE;
      cfg_r <= 9'h000;
      row_r <= 5'd0;
      sh_r <= '0;
      bits_r <= 5'd0;
      half_r <= 8'h00;
      tgt_r <= SCL_TGT_NONE;
      sclk_r <= 1'b0;
      sdata_r <= 1'b0;
      afe1_n_r <= 1'b1;
      afe2_n_r <= 1'b1;
      tg_n_r <= 1'b1;
      done_r <= 1'b0;
      pix_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      row_r <= row_nxt;
      sh_r <= sh_nxt;
      bits_r <= bits_nxt;
      half_r <= half_nxt;
      tgt_r <= tgt_nxt;
      sclk_r <= sclk_nxt;
      sdata_r <= sdata_nxt;
      afe1_n_r <= afe1_n_nxt;
      afe2_n_r <= afe2_n_nxt;
      tg_n_r <= tg_n_nxt;
      done_r <= done_nxt;
      pix_en_r <= pix_en_nxt;
    end
  end

  assign ser_sclk = sclk_r;
  assign ser_sdata = sdata_r;
  assign sload_afe1_n = afe1_n_r;
  assign sload_afe2_n = afe2_n_r;
  assign sload_tg_n = tg_n_r;
  assign load_done = done_r;
  assign pixel_data_clock_en = pix_en_r;

  //////////////////////////////////////////////////////////////////////////////////////////
  // monitor of the timing generator and the register slave

  logic [15:0] frames_r, frames_nxt;
  logic lv_seen_r, lv_seen_nxt, fv_seen_r, fv_seen_nxt, intg_seen_r, intg_seen_nxt;
  logic [1:0] ctrl_tgt_nxt;
  logic soft_restart_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic req, take, wr_take, clr_lo;

  assign req = avs_read || avs_write;
  assign take = req && !wait_r;
  assign wr_take = take && avs_write;
  assign clr_lo = wr_take && avs_address == `SCL_OFS_STATUS && avs_byteenable[0];

  always_comb begin
    // answer one cycle after the request is seen, with waitrequest low in that cycle only
    wait_nxt = !(req && wait_r);
    rdata_nxt = rdata_r;
    if (req && wait_r) begin
      case (avs_address)
        `SCL_OFS_CTRL: rdata_nxt = {30'd0, ctrl_tgt_r};
        `SCL_OFS_STATUS: rdata_nxt = {19'd0, row_r, 3'd0, intg_seen_r, fv_seen_r,
                                      lv_seen_r, state_r != SCL_ST_DONE, done_r};
        `SCL_OFS_FRAMES: rdata_nxt = {16'd0, frames_r};
        `SCL_OFS_CONFIG: rdata_nxt = {23'd0, cfg_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    ctrl_tgt_nxt = ctrl_tgt_r;
    soft_restart_nxt = 1'b0;
    if (wr_take && avs_address == `SCL_OFS_CTRL) begin
      if (avs_byteenable[0]) begin
        ctrl_tgt_nxt = avs_writedata[`SCL_CTRL_TGT_LSB +: 2];
      end
      if (avs_byteenable[1]) begin
        soft_restart_nxt = avs_writedata[`SCL_CTRL_RESTART_BIT];
      end
    end
    // sticky activity flags: a new event in the clearing cycle wins
    lv_seen_nxt = (lv_s && !lv3_r) ||
                  (lv_seen_r && !(clr_lo && avs_writedata[`SCL_ST_LV_BIT]));
    fv_seen_nxt = (fv_s && !fv3_r) ||
                  (fv_seen_r && !(clr_lo && avs_writedata[`SCL_ST_FV_BIT]));
    intg_seen_nxt = (intg2_r && !intg3_r) ||
                    (intg_seen_r && !(clr_lo && avs_writedata[`SCL_ST_INTG_BIT]));
    frames_nxt = frames_r;
    if (restart) begin
      frames_nxt = 16'h0000;
    end else if (done_r && fv_s && !fv3_r) begin
      frames_nxt = frames_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      ctrl_tgt_r <= `SCL_CTRL_RESET;
      soft_restart_r <= 1'b0;
      lv_seen_r <= 1'b0;
      fv_seen_r <= 1'b0;
      intg_seen_r <= 1'b0;
      frames_r <= 16'h0000;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      ctrl_tgt_r <= ctrl_tgt_nxt;
      soft_restart_r <= soft_restart_nxt;
      lv_seen_r <= lv_seen_nxt;
      fv_seen_r <= fv_seen_nxt;
      intg_seen_r <= intg_seen_nxt;
      frames_r <= frames_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

endmodule // scl_loader

/* File: verif/scl_loader_properties.sv */
// scl_loader_properties: port assertions for the loader
// assumes: bound to scl_loader, everything in the clk domain
`timescale 1ns/1ps
module scl_loader_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // watched ports
  input wire logic host_sload_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic ser_sclk,
  input wire logic ser_sdata,
  input wire logic sload_afe1_n,
  input wire logic sload_afe2_n,
  input wire logic sload_tg_n,
  input wire logic load_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic idle;
  logic tg_seen_r;
  logic tg_seen_nxt;
  assign idle = sload_afe1_n && sload_afe2_n && sload_tg_n;
  // once tg rows start, front-end rows are over for this load
  always_comb begin
    tg_seen_nxt = tg_seen_r;
    if (load_done) tg_seen_nxt = 1'b0;
    else if (!sload_tg_n) tg_seen_nxt = 1'b1;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) tg_seen_r <= 1'b0;
    else tg_seen_r <= tg_seen_nxt;
  end
  ////////////////////////////////////////////////////////////
  property p_one_sel; $onehot0({!sload_afe1_n, !sload_afe2_n, !sload_tg_n}); endproperty
  a_one_sel: assert property (p_one_sel) else $error("two loads low");
  property p_order; tg_seen_r |-> sload_afe1_n && sload_afe2_n; endproperty
  a_order: assert property (p_order) else $error("front-end row after tg row");
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_open; !load_done && $fell(idle) |-> !ser_sclk ##2 ser_sclk; endproperty
  a_open: assert property (p_open) else $error("frame start sclk wrong");
  property p_high; !load_done && $rose(ser_sclk) |=> ser_sclk ##1 !ser_sclk; endproperty
  a_high: assert property (p_high) else $error("sclk high time wrong");
  property p_hold;
    !load_done && $rose(ser_sclk) |-> $stable(ser_sdata) ##1 $stable(ser_sdata);
  endproperty
  a_hold: assert property (p_hold) else $error("sdata moved near sclk rise");
  property p_fwd_idle; (load_done && host_sload_n) [*8] |-> idle; endproperty
  a_fwd_idle: assert property (p_fwd_idle) else $error("load low with host idle");
  c_done: cover property ($rose(load_done));
  c_read: cover property (avs_read && !avs_waitrequest);
  c_fwd: cover property (load_done && !sload_tg_n);
endmodule // scl_loader_chk

bind scl_loader scl_loader_chk u_chk (.clk, .nrst, .host_sload_n, .avs_read, .avs_write,
  .avs_waitrequest, .ser_sclk, .ser_sdata, .sload_afe1_n, .sload_afe2_n, .sload_tg_n,
  .load_done);

/* File: verif/scl_far_model.sv */
// scl_far_model: front-end converters and timing generator on the serial link
// assumes: idle-low sclk, data taken on its rising edge, one load low at a time
`timescale 1ns/1ps
module scl_far_model (
  // clock
  input wire logic clk,
  // serial link in
  input wire logic ser_sclk,
  input wire logic ser_sdata,
  input wire logic sload_afe1_n,
  input wire logic sload_afe2_n,
  input wire logic sload_tg_n,
  // timing generator activity out
  output logic tg_line_valid,
  output logic tg_frame_valid,
  output logic tg_intg_start
);
  logic [25:0] rx_q[$];
  logic [23:0] sh;
  logic run = 1'b0;
  logic [5:0] cnt = 6'h0;
  initial {tg_line_valid, tg_frame_valid, tg_intg_start} = 3'h0;
  // a part shifts only while some load enable is low
  always @(posedge ser_sclk) begin
    if (!(sload_afe1_n && sload_afe2_n && sload_tg_n)) sh = {sh[22:0], ser_sdata};
  end
  // a word is taken when its load enable rises
  always @(posedge sload_afe1_n) rx_q.push_back({2'h1, sh});
  always @(posedge sload_afe2_n) rx_q.push_back({2'h2, sh});
  always @(posedge sload_tg_n) begin
    rx_q.push_back({2'h3, sh});
    if (sh[23:16] == 8'h02) run = sh[0];
  end
  ////////////////////////////////////////////////////////////
  // sequencer activity only in execution mode
  always @(posedge clk) begin
    cnt <= cnt + 6'h1;
    tg_frame_valid <= run && cnt[5];
    tg_line_valid <= run && cnt[2];
    tg_intg_start <= run && (cnt == 6'h3f);
  end
endmodule // scl_far_model

/* File: verif/scl_loader_bench.sv */
// scl_loader_bench: self-checking bench for the default loader
// assumes: far model on the serial link, checker bound from its own file
`timescale 1ns/1ps
module scl_loader_bench;
  logic clk, nrst, btn_n, remote, dual, bin, still, vari, hsclk, hsdata, hsload_n;
  logic lv, fv, intg, sclk, sdata, ld1_n, ld2_n, ldt_n, done, pclk_en, rd, wr, wait_rq;
  logic [4:0] sel;
  logic [3:0] addr, be;
  logic [31:0] wdata, rdata, v;
  logic c_dual, c_bin, c_still, c_var;
  logic [4:0] c_sel;
  int n_fail = 0;
  int samples_checked = 0;

  scl_loader dut (.clk(clk), .nrst(nrst), .board_reset_btn_n(btn_n),
    .remote_reset_input(remote), .channel_count_switch(dual), .binning_switch(bin),
    .capture_mode_switch(still), .sensor_variant_switch(vari),
    .integration_select_inputs(sel), .host_sclk(hsclk), .host_sdata(hsdata),
    .host_sload_n(hsload_n), .tg_line_valid(lv), .tg_frame_valid(fv), .tg_intg_start(intg),
    .ser_sclk(sclk), .ser_sdata(sdata), .sload_afe1_n(ld1_n), .sload_afe2_n(ld2_n),
    .sload_tg_n(ldt_n), .load_done(done), .pixel_data_clock_en(pclk_en),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_rq));
  scl_far_model far (.clk(clk), .ser_sclk(sclk), .ser_sdata(sdata), .sload_afe1_n(ld1_n),
    .sload_afe2_n(ld2_n), .sload_tg_n(ldt_n), .tg_line_valid(lv), .tg_frame_valid(fv),
    .tg_intg_start(intg));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report;
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one access; waits for waitrequest low, read data lands in v
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wait_rq !== 1'b0);
    v = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // config order matches the captured config word
  task automatic set_sw(input logic [8:0] c);
    {c_sel, c_var, c_still, c_bin, c_dual} = c;
    {sel, vari, still, bin, dual} <= c;
  endtask

  task automatic host_send(input logic [23:0] w);
    @(posedge clk);
    hsload_n <= 1'b0;
    for (int b = 23; b >= 0; b--) begin
      hsdata <= w[b];
      repeat (4) @(posedge clk);
      hsclk <= 1'b1;
      repeat (4) @(posedge clk);
      hsclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    hsload_n <= 1'b1;
    hsdata <= ~w[0];
    repeat (8) @(posedge clk);
  endtask

  function automatic logic [25:0] exp_row(input int i);
    logic [15:0] d;
    logic [15:0] r1 [10];
    r1 = '{c_dual ? 16'h0340 : 16'h0680, 16'h0009, 16'h0000, c_dual ? 16'h033a : 16'h0674,
      c_dual ? 16'h033c : 16'h065e, c_dual ? 16'h033d : 16'h0668, 16'h0000, 16'h0000,
      16'h0000, 16'h0008};
    case (i % 8)
      0: d = 16'h0080;
      1: d = c_var ? 16'h0194 : 16'h015e;
      2: d = 16'h0060;
      3: d = 16'h0008;
      default: d = 16'h002b;
    endcase
    if (i < 16) return {(i < 8) ? 2'h1 : 2'h2, 8'(i % 8), d};
    if (i == 16) return {2'h3, 8'h02, 16'h0000};
    if (i == 17) return {2'h3, 8'h00, c_bin ? 16'h0002 : {15'h0, c_still}};
    if (i == 29) return {2'h3, 8'h02, 16'h0001};
    if (i == 28) return {2'h3, 8'h04, (c_sel == 5'h0 || c_sel > 5'h7) ? 16'h0ff8 :
      16'((c_still ? 456 : 152) * (8 - c_sel))};
    return {2'h3, 8'h10 + 8'(i - 18), r1[i - 18]};
  endfunction

  // waits out the restart, then the whole load, and judges every row
  task automatic chk_load(input string nm);
    int n;
    n = 0;
    while (done === 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    while (done !== 1'b1 && n < 8000) begin
      @(posedge clk);
      n++;
    end
    chk({nm, " rows"}, 32'd30, 32'(far.rx_q.size()));
    for (int i = 0; i < far.rx_q.size() && i < 30; i++) begin
      chk(nm, 32'(exp_row(i)), 32'(far.rx_q[i]));
    end
    far.rx_q.delete();
    bus(1'b0, 4'hc, 32'h0);
    chk({nm, " cfg"}, {23'h0, c_sel, c_var, c_still, c_bin, c_dual}, v);
    bus(1'b0, 4'h4, 32'h0);
    chk({nm, " done"}, 32'h1, {31'h0, v[0]});
    chk({nm, " pclk"}, 32'h1, {31'h0, pclk_en});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #1500000;
    n_fail++;
    final_report();
  end

  initial begin
    {nrst, remote, hsclk, hsdata, rd, wr} = 6'h0;
    {btn_n, hsload_n, be, addr, wdata} = {2'h3, 4'hf, 4'h0, 32'h0};
    set_sw({5'h03, 4'h8});
    repeat (4) @(posedge clk);
    chk("reset out", 32'hf0, {24'h0, ld1_n, ld2_n, ldt_n, wait_rq, sclk, sdata, done,
      pclk_en});
    chk("reset rdata", 32'h0, rdata);
    nrst <= 1'b1;
    far.rx_q.delete();
    // switches move mid-load; the captured set must still rule
    repeat (300) @(posedge clk);
    {sel, vari, still, bin, dual} <= {5'h1c, 4'h7};
    chk_load("load single");
    repeat (200) @(posedge clk);
    bus(1'b0, 4'h4, 32'h0);
    chk("tg activity", 32'h7, {29'h0, v[4:2]});
    bus(1'b0, 4'h8, 32'h0);
    chk("frames seen", 32'h1, {31'h0, |v[15:0]});
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, v);
    set_sw({5'h00, 4'he});
    bus(1'b1, 4'h0, 32'h3);
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl tgt", 32'h3, {30'h0, v[1:0]});
    far.rx_q.delete();
    host_send(24'h140123);
    chk("host fwd", {6'h0, 2'h3, 24'h140123}, 32'(far.rx_q[0]));
    far.rx_q.delete();
    bus(1'b1, 4'h0, 32'h103);
    chk_load("ctrl restart");
    {sel, vari, still, bin, dual} <= {5'h07, 4'h5};
    repeat (10) @(posedge clk);
    bus(1'b0, 4'hc, 32'h0);
    chk("cfg before reset", {23'h0, c_sel, c_var, c_still, c_bin, c_dual}, v);
    set_sw({5'h07, 4'h5});
    remote <= 1'b1;
    repeat (10) @(posedge clk);
    far.rx_q.delete();
    remote <= 1'b0;
    chk_load("remote reset");
    set_sw({5'h08, 4'h4});
    btn_n <= 1'b0;
    repeat (10) @(posedge clk);
    far.rx_q.delete();
    btn_n <= 1'b1;
    chk_load("button reset");
    final_report();
  end
endmodule // scl_loader_bench
